// ### rtl/proof_if.sv
// signals between the supervisor and one proof timer
// assumes the supervisor drives tick, start, armed and proof each cycle
interface proof_if;
  logic tick;
  logic start;
  logic armed;
  logic proof;
  logic late;
  modport timer (input tick, input start, input armed, input proof, output late);
  modport sup (output tick, output start, output armed, output proof, input late);
endinterface

// ### rtl/proof_timer.sv
// proof-of-action timer for one commanded fan or damper
// assumes a one-cycle seconds tick and a start pulse per new command
module proof_timer
  import smoke_pkg::*;
#(
  parameter int LIMIT_S = FAN_PROOF_S
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // supervisor side
  proof_if.timer pif
);
  localparam int CNT_W = $clog2(LIMIT_S + 1);
  localparam logic [CNT_W-1:0] LIMIT_CNT = CNT_W'(LIMIT_S);

  tstate_t state_ff;
  logic [CNT_W-1:0] sec_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= T_IDLE;
      sec_ff <= '0;
    end else if (ce) begin
      if (!pif.armed) begin
        state_ff <= T_IDLE;
        sec_ff <= '0;
      end else if (pif.start) begin
        state_ff <= T_RUN;
        sec_ff <= '0;
      end else begin
        case (state_ff)
          T_RUN: begin
            if (pif.proof) begin
              state_ff <= T_IDLE;
            end else if (pif.tick) begin
              if (sec_ff == LIMIT_CNT - CNT_W'(1)) begin
                state_ff <= T_LATE;
              end
              sec_ff <= sec_ff + CNT_W'(1);
            end
          end
          T_LATE: begin
            if (pif.proof) begin
              state_ff <= T_IDLE;
            end
          end
          T_IDLE: state_ff <= T_IDLE;
          default: state_ff <= T_IDLE;
        endcase
      end
    end
  end

  assign pif.late = (state_ff == T_LATE);
endmodule

// ### rtl/smoke_control_supervisor.sv
// firefighter station supervisor: alarm latch, zone commands, proof timing, fault
// assumes synchronous field inputs, one clock, proof timers from proof_timer
module smoke_control_supervisor
  import smoke_pkg::*;
#(
  parameter int ZONES = ZONES_DEF,
  parameter int ANA_CH = ANA_CH_DEF,
  parameter int CYCLES_PER_SEC = CLK_HZ,
  parameter int FAN_LIMIT_S = FAN_PROOF_S,
  parameter int DMP_LIMIT_S = DMP_PROOF_S,
  parameter int RESOUND_LIMIT_S = RESOUND_S
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // fire alarm panel contacts, one per zone, and latch clear
  input wire logic [ZONES-1:0] FIRE_ALARM_PANEL_IN,
  input wire logic ALARM_CLR,
  // firefighter station mode switches, three bits per zone
  input wire logic [ZONES*MODE_W-1:0] MODE_SW,
  input wire logic SILENCE_KEY,
  // proof feedback
  input wire logic [ZONES-1:0] FAN_PROOF,
  input wire logic [ZONES-1:0] DMP_END_IN,
  input wire logic STAIR_PROOF,
  // analog inputs
  input wire logic [ANA_CH*ANA_W-1:0] ANA_CODE,
  // commands to field controllers
  output logic [ZONES*MODE_W-1:0] ZONE_CMD,
  output logic [ZONES-1:0] CMD_STROBE,
  output logic STAIR_PRESS,
  output logic STAIR_STROBE,
  // alarm latch state and manual mode flag
  output logic ALARM_LATCHED,
  output logic [$clog2(ZONES)-1:0] FIRE_ZONE,
  output logic MANUAL_ACTIVE,
  // proof and fault indication
  output logic [ZONES-1:0] FAN_LATE,
  output logic [ZONES-1:0] DMP_LATE,
  output logic STAIR_LATE,
  output logic FAULT_LED,
  output logic HORN,
  // converted analog values in millivolts
  output logic [ANA_CH*ANA_MV_W-1:0] ANA_MV
);
  localparam int ZW = $clog2(ZONES);
  localparam int TICK_W = $clog2(CYCLES_PER_SEC);
  localparam int RES_W = $clog2(RESOUND_LIMIT_S + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLES_PER_SEC - 1);
  localparam logic [RES_W-1:0] RES_LAST = RES_W'(RESOUND_LIMIT_S - 1);

  // lowest zone with an alarm present
  function automatic logic [ZW-1:0] first_zone(input logic [ZONES-1:0] v);
    logic [ZW-1:0] idx;
    idx = '0;
    for (int i = ZONES - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = ZW'(i);
      end
    end
    return idx;
  endfunction

  // code * full scale / max code, product fits 26 bits
  function automatic logic [ANA_MV_W-1:0] code_to_mv(input logic [ANA_W-1:0] code);
    logic [25:0] prod;
    prod = 26'(code) * 26'(ANA_FS_MV);
    return ANA_MV_W'(prod / 26'(ANA_CODE_MAX));
  endfunction

  logic [TICK_W-1:0] tick_cnt_ff;
  logic tick_ff;
  zmode_t sw_mode [ZONES];
  zmode_t nxt_cmd [ZONES];
  zmode_t cmd_ff [ZONES];
  logic [ZONES-1:0] strobe_ff;
  logic [ZONES-1:0] alarm_on;
  logic [ZONES-1:0] sw_manual;
  logic [ZONES-1:0] damper_closed;
  logic manual;
  logic latched_ff;
  logic [ZW-1:0] fire_zone_ff;
  logic nxt_stair;
  logic stair_ff;
  logic stair_strobe_ff;
  logic [ZONES-1:0] fan_late;
  logic [ZONES-1:0] dmp_late;
  logic stair_late;
  logic fault;
  logic fault_led_ff;
  logic horn_ff;
  logic silenced_ff;
  logic [RES_W-1:0] resound_cnt_ff;
  logic key_q_ff;
  logic [ANA_CH*ANA_MV_W-1:0] ana_mv_ff;

  // seconds timebase
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (CE) begin
      tick_ff <= (tick_cnt_ff == TICK_LAST);
      if (tick_cnt_ff == TICK_LAST) begin
        tick_cnt_ff <= '0;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
      end
    end
  end

  // input decoding
  for (genvar z = 0; z < ZONES; z++) begin : g_dec
    assign sw_mode[z] = decode_mode(MODE_SW[z*MODE_W +: MODE_W]);
    assign sw_manual[z] = (sw_mode[z] != MODE_AUTO);
    assign alarm_on[z] = bin_on(FIRE_ALARM_PANEL_IN[z]);
    assign damper_closed[z] = bin_on(DMP_END_IN[z]);
  end
  assign manual = |sw_manual;

  // first-alarm latch; a new alarm in the clearing cycle is latched
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      latched_ff <= 1'b0;
      fire_zone_ff <= '0;
    end else if (CE) begin
      if ((!latched_ff || ALARM_CLR) && !manual && (|alarm_on)) begin
        latched_ff <= 1'b1;
        fire_zone_ff <= first_zone(alarm_on);
      end else if (ALARM_CLR) begin
        latched_ff <= 1'b0;
      end
      // otherwise later alarms are dropped and the first zone stays
    end
  end

  // zone command selection
  always_comb begin
    int fz;
    fz = int'(fire_zone_ff);
    nxt_stair = 1'b0;
    for (int z = 0; z < ZONES; z++) begin
      nxt_cmd[z] = MODE_AUTO;
      if (manual) begin
        nxt_cmd[z] = sw_mode[z];
        if (sw_mode[z] == MODE_EXHAUST) begin
          nxt_stair = 1'b1;
        end
      end else if (latched_ff) begin
        if (z == fz) begin
          nxt_cmd[z] = MODE_EXHAUST;
        end else if ((z == fz + 1) || (z + 1 == fz)) begin
          nxt_cmd[z] = MODE_PRESS;
        end
      end
    end
    if (!manual && latched_ff) begin
      nxt_stair = 1'b1;
    end
  end

  // command registers and change strobes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int z = 0; z < ZONES; z++) begin
        cmd_ff[z] <= MODE_AUTO;
      end
      strobe_ff <= '0;
      stair_ff <= 1'b0;
      stair_strobe_ff <= 1'b0;
    end else if (CE) begin
      for (int z = 0; z < ZONES; z++) begin
        cmd_ff[z] <= nxt_cmd[z];
        strobe_ff[z] <= (nxt_cmd[z] != cmd_ff[z]);
      end
      stair_ff <= nxt_stair;
      stair_strobe_ff <= (nxt_stair != stair_ff);
    end
  end

  // proof timers, fan and damper per zone
  for (genvar z = 0; z < ZONES; z++) begin : g_proof
    proof_if fan_if ();
    proof_if dmp_if ();
    assign fan_if.tick = tick_ff;
    assign fan_if.armed = (cmd_ff[z] != MODE_AUTO);
    assign fan_if.start = strobe_ff[z] && (cmd_ff[z] != MODE_AUTO);
    assign fan_if.proof = FAN_PROOF[z];
    assign dmp_if.tick = tick_ff;
    assign dmp_if.armed = (cmd_ff[z] != MODE_AUTO);
    assign dmp_if.start = strobe_ff[z] && (cmd_ff[z] != MODE_AUTO);
    assign dmp_if.proof = damper_closed[z];
    proof_timer #(
      .LIMIT_S(FAN_LIMIT_S)
    ) u_fan (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .pif(fan_if.timer)
    );
    proof_timer #(
      .LIMIT_S(DMP_LIMIT_S)
    ) u_dmp (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .pif(dmp_if.timer)
    );
    assign fan_late[z] = fan_if.late;
    assign dmp_late[z] = dmp_if.late;
  end

  // stairwell fan proof
  proof_if stair_if ();
  assign stair_if.tick = tick_ff;
  assign stair_if.armed = stair_ff;
  assign stair_if.start = stair_strobe_ff && stair_ff;
  assign stair_if.proof = STAIR_PROOF;
  proof_timer #(
    .LIMIT_S(FAN_LIMIT_S)
  ) u_stair (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .pif(stair_if.timer)
  );
  assign stair_late = stair_if.late;

  assign fault = (|fan_late) || (|dmp_late) || stair_late;

  // silence key and 24 h resound
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      key_q_ff <= 1'b0;
      silenced_ff <= 1'b0;
      resound_cnt_ff <= '0;
    end else if (CE) begin
      key_q_ff <= SILENCE_KEY;
      if (!fault) begin
        silenced_ff <= 1'b0;
        resound_cnt_ff <= '0;
      end else if (SILENCE_KEY && !key_q_ff && !silenced_ff) begin
        silenced_ff <= 1'b1;
        resound_cnt_ff <= '0;
      end else if (silenced_ff && tick_ff) begin
        if (resound_cnt_ff == RES_LAST) begin
          silenced_ff <= 1'b0;
          resound_cnt_ff <= '0;
        end else begin
          resound_cnt_ff <= resound_cnt_ff + RES_W'(1);
        end
      end
    end
  end

  // indications
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fault_led_ff <= 1'b0;
      horn_ff <= 1'b0;
    end else if (CE) begin
      fault_led_ff <= fault;
      horn_ff <= fault && !silenced_ff;
    end
  end

  // analog conversion
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ana_mv_ff <= '0;
    end else if (CE) begin
      for (int c = 0; c < ANA_CH; c++) begin
        ana_mv_ff[c*ANA_MV_W +: ANA_MV_W] <= code_to_mv(ANA_CODE[c*ANA_W +: ANA_W]);
      end
    end
  end

  // outputs
  for (genvar z = 0; z < ZONES; z++) begin : g_out
    assign ZONE_CMD[z*MODE_W +: MODE_W] = cmd_ff[z];
  end
  assign CMD_STROBE = strobe_ff;
  assign STAIR_PRESS = stair_ff;
  assign STAIR_STROBE = stair_strobe_ff;
  assign ALARM_LATCHED = latched_ff;
  assign FIRE_ZONE = fire_zone_ff;
  assign MANUAL_ACTIVE = manual;
  assign FAN_LATE = fan_late;
  assign DMP_LATE = dmp_late;
  assign STAIR_LATE = stair_late;
  assign FAULT_LED = fault_led_ff;
  assign HORN = horn_ff;
  assign ANA_MV = ana_mv_ff;
endmodule

// ### rtl/smoke_pkg.sv
// constants, mode codes and helper functions of the smoke control supervisor
// assumes a single 50 MHz clock domain; all field inputs already synchronous
package smoke_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int FAN_PROOF_S = 60;
  localparam int DMP_PROOF_S = 75;
  localparam int RESOUND_H = 24;
  localparam int RESOUND_S = RESOUND_H * 3600;
  localparam int ZONES_DEF = 4;
  localparam int ANA_CH_DEF = 2;
  localparam int ANA_W = 12;
  localparam int ANA_MV_W = 14;
  localparam int ANA_FS_MV = 12000;
  localparam int ANA_CODE_MAX = 4095;
  localparam int MODE_W = 3;
  localparam logic BIN_ON_LEVEL = 1'b0;

  typedef enum logic [2:0] {
    MODE_AUTO = 3'h0,
    MODE_PRESS = 3'h1,
    MODE_OFF = 3'h2,
    MODE_PURGE = 3'h3,
    MODE_EXHAUST = 3'h4
  } zmode_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_RUN = 3'b010,
    T_LATE = 3'b100
  } tstate_t;

  // rotary switch code to zone mode; unknown codes fall back to automatic
  function automatic zmode_t decode_mode(input logic [2:0] raw);
    zmode_t m;
    m = MODE_AUTO;
    case (raw)
      3'h1: m = MODE_PRESS;
      3'h2: m = MODE_OFF;
      3'h3: m = MODE_PURGE;
      3'h4: m = MODE_EXHAUST;
      default: m = MODE_AUTO;
    endcase
    return m;
  endfunction

  // contact input: shorted to ground reads on, open pull-up reads off
  function automatic logic bin_on(input logic raw);
    return raw == BIN_ON_LEVEL;
  endfunction
endpackage

// ### tb/field_ctrl_model.sv
// field controllers: fan, damper and stair proof after travel time
// assumes zone commands from the supervisor; hold withholds every proof
module field_ctrl_model #(
  parameter int ZONES = 4,
  parameter int DELAY = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic [ZONES*3-1:0] zone_cmd,
  input wire logic stair_press,
  output logic [ZONES-1:0] fan_proof,
  output logic [ZONES-1:0] dmp_end_n,
  output logic stair_proof
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ZONES-1:0] want;
  logic [ZONES*3-1:0] last_ff;
  int age_ff;
  always_comb begin
    for (int z = 0; z < ZONES; z++) begin
      want[z] = zone_cmd[3*z +: 3] != 3'h0;
    end
  end
  // travel time restarts on any new command
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      last_ff <= '0;
      age_ff <= 0;
    end else begin
      last_ff <= zone_cmd;
      age_ff <= (zone_cmd != last_ff) ? 0 : (age_ff < 100 ? age_ff + 1 : age_ff);
    end
  end
  assign fan_proof = (!hold && age_ff >= DELAY) ? want : '0;
  // open end switch floats to the pull-up
  assign dmp_end_n = ~fan_proof;
  assign stair_proof = !hold && age_ff >= DELAY && stair_press;
endmodule

// ### tb/smoke_control_supervisor_test.sv
// testbench for the smoke control supervisor
// assumes shortened seconds and limits; field controller model on the far side
module smoke_control_supervisor_test;
  import smoke_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, alarm_clr, silence, hold, stair_proof;
  logic [3:0] alarm_in, fan_proof, dmp_end_n, cmd_strobe, fan_late, dmp_late;
  logic [11:0] mode_sw, zone_cmd;
  logic [23:0] ana_code;
  logic [27:0] ana_mv;
  logic [1:0] fire_zone;
  logic stair_press, stair_strobe, latched, manual, stair_late, fault_led, horn;
  int num_errors = 0;
  int num_checks = 0;
  smoke_control_supervisor #(.CYCLES_PER_SEC(4), .FAN_LIMIT_S(2),
    .DMP_LIMIT_S(3), .RESOUND_LIMIT_S(3)) u_dut (.CLK(clk), .RST(rst), .CE(ce),
    .FIRE_ALARM_PANEL_IN(alarm_in), .ALARM_CLR(alarm_clr), .MODE_SW(mode_sw), .SILENCE_KEY(silence),
    .FAN_PROOF(fan_proof), .DMP_END_IN(dmp_end_n), .STAIR_PROOF(stair_proof), .ANA_CODE(ana_code),
    .ZONE_CMD(zone_cmd), .CMD_STROBE(cmd_strobe), .STAIR_PRESS(stair_press), .STAIR_STROBE(stair_strobe),
    .ALARM_LATCHED(latched), .FIRE_ZONE(fire_zone), .MANUAL_ACTIVE(manual), .FAN_LATE(fan_late),
    .DMP_LATE(dmp_late), .STAIR_LATE(stair_late), .FAULT_LED(fault_led), .HORN(horn), .ANA_MV(ana_mv));
  field_ctrl_model u_field (.clk(clk), .rst(rst), .hold(hold),
    .zone_cmd(zone_cmd), .stair_press(stair_press), .fan_proof(fan_proof), .dmp_end_n(dmp_end_n),
    .stair_proof(stair_proof));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      num_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      test_done();
    end
  endtask
  task automatic t_manual();
    for (int c = 0; c < 8; c++) begin
      mode_sw[2:0] = c[2:0];
      step(1);
      chk(zone_cmd[2:0], c < 5 ? c : 0);
      chk(cmd_strobe[0], c >= 1 && c <= 5);
      chk(manual, c >= 1 && c <= 4);
    end
    mode_sw[2:0] = 3'h2;
    step(1);
    alarm_in = 4'hD;
    step(3);
    chk(latched, 0);
    alarm_in = 4'hF;
    mode_sw = '0;
    step(2);
    chk(zone_cmd, 0);
  endtask
  task automatic t_alarm();
    alarm_in = 4'hB;
    step(1);
    chk(latched, 1);
    chk(fire_zone, 2);
    step(1);
    chk(zone_cmd, {3'h1, 3'h4, 3'h1, 3'h0});
    chk(stair_press, 1);
    chk(stair_strobe, 1);
    alarm_in = 4'h0;
    step(3);
    chk(fire_zone, 2);
    chk(zone_cmd, {3'h1, 3'h4, 3'h1, 3'h0});
    alarm_in = 4'hF;
    alarm_clr = 1'b1;
    step(1);
    alarm_clr = 1'b0;
    step(2);
    chk(zone_cmd, 0);
  endtask
  task automatic t_late();
    int n;
    hold = 1'b1;
    alarm_in = 4'hE;
    for (n = 0; n < 40 && fan_late[0] !== 1'b1; n++) step(1);
    tmo(n);
    chk(n > 4 && n < 14, 1);
    chk(dmp_late[0], 0);
    for (n = 0; n < 40 && dmp_late[0] !== 1'b1; n++) step(1);
    tmo(n);
    chk(stair_late, 1);
    step(2);
    chk(fault_led, 1);
    chk(horn, 1);
    silence = 1'b1;
    step(2);
    silence = 1'b0;
    chk(horn, 0);
    step(4);
    chk(horn, 0);
    chk(fault_led, 1);
    for (n = 0; n < 40 && horn !== 1'b1; n++) step(1);
    tmo(n);
    hold = 1'b0;
    step(3);
    chk({fan_late[0], dmp_late[0], stair_late}, 0);
    step(2);
    chk({fault_led, horn}, 0);
    alarm_in = 4'hF;
    alarm_clr = 1'b1;
    step(1);
    alarm_clr = 1'b0;
    step(3);
  endtask
  task automatic t_analog();
    ana_code = {12'hFFF, 12'h000};
    step(2);
    chk(ana_mv, {14'h2EE0, 14'h0});
    ana_code = {12'h800, 12'h001};
    step(2);
    chk(ana_mv, {14'h1771, 14'h2});
  endtask
  // enable low freezes commands and conversion
  task automatic t_freeze();
    ce = 1'b0;
    mode_sw[2:0] = 3'h4;
    ana_code = {12'hFFF, 12'hFFF};
    step(3);
    chk(manual, 1);
    chk(zone_cmd, 0);
    chk(ana_mv, {14'h1771, 14'h2});
    ce = 1'b1;
    step(1);
    chk(zone_cmd[2:0], 3'h4);
    chk(cmd_strobe[0], 1);
    chk(stair_press, 1);
    mode_sw = '0;
    step(2);
    chk(zone_cmd, 0);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    alarm_in = 4'hF;
    alarm_clr = 1'b0;
    mode_sw = '0;
    silence = 1'b0;
    hold = 1'b0;
    ana_code = '0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    step(2);
    t_manual();
    t_alarm();
    t_late();
    t_analog();
    t_freeze();
    test_done();
  end
endmodule
bind smoke_control_supervisor smoke_sva #(.ZONES(ZONES), .CYCLES_PER_SEC(CYCLES_PER_SEC),
  .FAN_LIMIT_S(FAN_LIMIT_S)) u_sva (.CLK(CLK), .RST(RST), .CE(CE),
  .FIRE_ALARM_PANEL_IN(FIRE_ALARM_PANEL_IN), .ALARM_CLR(ALARM_CLR), .FAN_PROOF(FAN_PROOF),
  .ZONE_CMD(ZONE_CMD), .CMD_STROBE(CMD_STROBE), .STAIR_PRESS(STAIR_PRESS), .ALARM_LATCHED(ALARM_LATCHED),
  .FIRE_ZONE(FIRE_ZONE), .MANUAL_ACTIVE(MANUAL_ACTIVE), .FAN_LATE(FAN_LATE), .DMP_LATE(DMP_LATE),
  .STAIR_LATE(STAIR_LATE), .FAULT_LED(FAULT_LED), .HORN(HORN));

// ### tb/smoke_sva.sv
// port assertions for the smoke control supervisor
// assumes shortened timing parameters handed on by the bind
module smoke_sva
  import smoke_pkg::*;
#(
  parameter int ZONES = ZONES_DEF,
  parameter int CYCLES_PER_SEC = 4,
  parameter int FAN_LIMIT_S = 2
) (
  // clock and inputs
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [ZONES-1:0] FIRE_ALARM_PANEL_IN,
  input wire logic ALARM_CLR,
  input wire logic [ZONES-1:0] FAN_PROOF,
  // outputs
  input wire logic [ZONES*MODE_W-1:0] ZONE_CMD,
  input wire logic [ZONES-1:0] CMD_STROBE,
  input wire logic STAIR_PRESS,
  input wire logic ALARM_LATCHED,
  input wire logic [$clog2(ZONES)-1:0] FIRE_ZONE,
  input wire logic MANUAL_ACTIVE,
  input wire logic [ZONES-1:0] FAN_LATE,
  input wire logic [ZONES-1:0] DMP_LATE,
  input wire logic STAIR_LATE,
  input wire logic FAULT_LED,
  input wire logic HORN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [ZONES-1:0] prev_alarm_ff;
  logic armed_ff;
  int cnt_ff;
  wire late_any = |{FAN_LATE, DMP_LATE, STAIR_LATE};
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) prev_alarm_ff <= '1;
    else prev_alarm_ff <= FIRE_ALARM_PANEL_IN;
  end
  // cycles since zone 0 was last commanded
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      armed_ff <= 1'b0;
      cnt_ff <= 0;
    end else if (CMD_STROBE[0]) begin
      armed_ff <= ZONE_CMD[2:0] != 3'h0;
      cnt_ff <= 1;
    end else if (FAN_PROOF[0]) armed_ff <= 1'b0;
    else if (CE && cnt_ff < 1000) cnt_ff <= cnt_ff + 1;
  end
  sequence s_latch;
    $rose(ALARM_LATCHED) && CE && !MANUAL_ACTIVE;
  endsequence
  sequence s_overdue;
    armed_ff && !FAN_PROOF[0] && cnt_ff >= FAN_LIMIT_S * CYCLES_PER_SEC + 4;
  endsequence
  first_alarm_a: assert property ($rose(ALARM_LATCHED) |-> !prev_alarm_ff[FIRE_ZONE])
    else $error("latched zone had no alarm");
  latch_hold_a: assert property (ALARM_LATCHED && !ALARM_CLR |=> ALARM_LATCHED && $stable(FIRE_ZONE))
    else $error("latched zone changed");
  manual_block_a: assert property (MANUAL_ACTIVE && !ALARM_LATCHED |=> !ALARM_LATCHED)
    else $error("alarm latched in manual mode");
  auto_quiet_a: assert property (CE && !MANUAL_ACTIVE && !ALARM_LATCHED |=> ZONE_CMD == '0)
    else $error("command issued while all auto");
  strobe_cmd_a: assert property ($changed(ZONE_CMD[2:0]) |-> CMD_STROBE[0])
    else $error("command change without strobe");
  floor_plan_a: assert property (s_latch |=> ZONE_CMD[MODE_W*FIRE_ZONE +: MODE_W] == MODE_EXHAUST && STAIR_PRESS)
    else $error("fire zone not exhausting");
  fan_early_a: assert property ($rose(FAN_LATE[0]) |-> cnt_ff >= (FAN_LIMIT_S - 1) * CYCLES_PER_SEC - 1)
    else $error("fan late too early");
  fan_overdue_a: assert property (s_overdue |-> FAN_LATE[0])
    else $error("fan late missing");
  proof_cancel_a: assert property (CE && FAN_PROOF[0] |=> !FAN_LATE[0])
    else $error("late kept despite proof");
  fault_led_a: assert property (CE |=> FAULT_LED == $past(late_any))
    else $error("fault light wrong");
  horn_fault_a: assert property (HORN |-> FAULT_LED)
    else $error("horn without fault");
endmodule
